/* File: hdl/titq_top.sv */
// The register offsets and the address-and-strobe port are this design's own decisions.
module titq_top
   import titq_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   // register port
   input wire logic [3:0] ADDR_I,
   input wire logic [DAT_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [DAT_W-1:0] RDATA_O,
   // timer pins
   input wire logic [NUM_CNT-1:0] GATE_I,
   input wire logic [NUM_CNT-1:0] EVT_CLK_I,
   // serial buffer status
   input wire logic SER_RX_FULL_I,
   input wire logic SER_TX_EMPTY_I,
   // timer outputs
   output logic BAUD_CLK_O,
   output logic TMR1_OUT_O,
   output logic TMR2_OUT_O,
   // interrupt requests
   output logic SER_RX_IRQ_O,
   output logic SER_TX_IRQ_O,
   output logic TMR1_IRQ_O,
   output logic TMR2_IRQ_O,
   output logic IRQ_O
);

   default clocking dck @(posedge REF_CLK_I);
   endclocking
   default disable iff (RST_I);

   localparam int unsigned IN_W = 2 * NUM_CNT + 2;
   localparam int unsigned IN_EVT = NUM_CNT;
   localparam int unsigned IN_RX = 2 * NUM_CNT;
   localparam int unsigned IN_TX = 2 * NUM_CNT + 1;

   function automatic logic is_cnt(input logic [3:0] a);
      return (a == ADR_CNT0) || (a == ADR_CNT1) || (a == ADR_CNT2);
   endfunction

   function automatic titq_mode_t mode_of(input logic [2:0] c);
      titq_mode_t m;
      case (c)
         3'h1: m = MD_ONESHOT;
         3'h2: m = MD_RATE;
         3'h3: m = MD_SQUARE;
         3'h4: m = MD_SWSTB;
         3'h5: m = MD_HWSTB;
         default: m = MD_TCINT;
      endcase
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers: a change counts once stages two and three agree
   logic [IN_W-1:0] in_raw, s1_q, s2_q, s3_q, filt_q, filt_d, rise_q;

   assign in_raw = {SER_TX_EMPTY_I, SER_RX_FULL_I, EVT_CLK_I, GATE_I};
   assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         filt_q <= '0;
         rise_q <= '0;
      end else begin
         s1_q <= in_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
         rise_q <= filt_d & ~filt_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [DAT_W-1:0] jmp_q, rdata_q;
   logic [ST_W-1:0] stat_q, mask_q, stat_set;
   logic [NUM_CNT-1:0] wr_hi_q, rd_hi_q, cfg_wr_q, load_q, tick;
   logic [DAT_W-1:0] lsb_q [NUM_CNT];
   logic [DAT_W-1:0] hold_q [NUM_CNT];
   logic [CNT_W-1:0] load_val_q [NUM_CNT];
   titq_cfg_t cfg_bus_q;
   titq_cst_t cst [NUM_CNT];
   logic [1:0] widx, ridx, csel;
   logic wr_cnt, rd_cnt, wr_ctl;

   assign widx = ADDR_I[1:0];
   assign ridx = ADDR_I[1:0];
   assign csel = WDATA_I[CW_SEL_LO+:2];
   assign wr_cnt = WR_I && is_cnt(ADDR_I);
   assign rd_cnt = RD_I && is_cnt(ADDR_I);
   assign wr_ctl = WR_I && (ADDR_I == ADR_CTRL) && (csel != 2'h3);

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         jmp_q <= BYTE_ZERO;
         mask_q <= '0;
      end else if (WR_I && ADDR_I == ADR_JMP) begin
         jmp_q <= WDATA_I;
      end else if (WR_I && ADDR_I == ADR_MASK) begin
         mask_q <= WDATA_I[ST_W-1:0];
      end
   end

   // two byte load: low then high; high completes the load
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         wr_hi_q <= '0;
         load_q <= '0;
         cfg_wr_q <= '0;
         cfg_bus_q <= '{mode: MD_TCINT, bcd: 1'b0};
         for (int i = 0; i < NUM_CNT; i++) begin
            lsb_q[i] <= BYTE_ZERO;
            load_val_q[i] <= CNT_ZERO;
         end
      end else begin
         load_q <= '0;
         cfg_wr_q <= '0;
         if (wr_cnt) begin
            wr_hi_q[widx] <= !wr_hi_q[widx];
            if (!wr_hi_q[widx]) begin
               lsb_q[widx] <= WDATA_I;
            end else begin
               load_q[widx] <= 1'b1;
               load_val_q[widx] <= {WDATA_I, lsb_q[widx]};
            end
         end else if (wr_ctl) begin
            wr_hi_q[csel] <= 1'b0;
            cfg_wr_q[csel] <= 1'b1;
            cfg_bus_q <= '{mode: mode_of(WDATA_I[CW_MODE_LO+:3]), bcd: WDATA_I[CW_BCD]};
         end
      end
   end

   // live read: low byte snapshots the high byte so the pair never tears
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         rd_hi_q <= '0;
         for (int i = 0; i < NUM_CNT; i++) hold_q[i] <= BYTE_ZERO;
      end else if (rd_cnt) begin
         rd_hi_q[ridx] <= !rd_hi_q[ridx];
         if (!rd_hi_q[ridx]) hold_q[ridx] <= cst[ridx].count[CNT_W-1:DAT_W];
      end else if (wr_ctl) begin
         rd_hi_q[csel] <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         rdata_q <= BYTE_ZERO;
      end else begin
         rdata_q <= BYTE_ZERO;
         if (rd_cnt) begin
            rdata_q <= rd_hi_q[ridx] ? hold_q[ridx] : cst[ridx].count[DAT_W-1:0];
         end else if (RD_I) begin
            unique case (ADDR_I)
               ADR_STAT: rdata_q <= DAT_W'(stat_q);
               ADR_MASK: rdata_q <= DAT_W'(mask_q);
               ADR_JMP: rdata_q <= jmp_q;
               ADR_LIVE: rdata_q <= DAT_W'({filt_q[IN_TX], filt_q[IN_RX],
                                            cst[2].out, cst[1].out, cst[0].out});
               default: rdata_q <= BYTE_ZERO;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky status, cleared by reading it; a new event wins over the clear
   assign stat_set = {rise_q[IN_TX], rise_q[IN_RX], cst[2].tc, cst[1].tc, cst[0].tc};

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) stat_q <= '0;
      else if (RD_I && ADDR_I == ADR_STAT) stat_q <= stat_set;
      else stat_q <= stat_q | stat_set;
   end

   ////////////////////////////////////////////////////////////////////////////
   // internal timer input clock
   logic [DIV_W-1:0] div_q;
   logic int_tick_q;

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         div_q <= DIV_ZERO;
         int_tick_q <= 1'b0;
      end else if (div_q >= (jmp_q[JMP_SLOW] ? SLOW_LIM : FAST_LIM)) begin
         div_q <= DIV_ZERO;
         int_tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 7'h01;
         int_tick_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // the three counters
   for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
      // jumper picks the external event edge instead of the internal tick
      assign tick[g] = jmp_q[JMP_EVT_LO + g] ? rise_q[IN_EVT + g] : int_tick_q;
      titq_counter u_cnt (
         .clk_i(REF_CLK_I),
         .rst_i(RST_I),
         .tick_i(tick[g]),
         .gate_i(filt_q[g]),
         .gate_rise_i(rise_q[g]),
         .cfg_wr_i(cfg_wr_q[g]),
         .cfg_i(cfg_bus_q),
         .load_i(load_q[g]),
         .load_val_i(load_val_q[g]),
         .st_o(cst[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs; a jumper left off holds its line low
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         BAUD_CLK_O <= 1'b0;
         TMR1_OUT_O <= 1'b0;
         TMR2_OUT_O <= 1'b0;
         SER_RX_IRQ_O <= 1'b0;
         SER_TX_IRQ_O <= 1'b0;
         TMR1_IRQ_O <= 1'b0;
         TMR2_IRQ_O <= 1'b0;
         IRQ_O <= 1'b0;
      end else begin
         BAUD_CLK_O <= cst[0].out;
         TMR1_OUT_O <= jmp_q[JMP_RT1] && cst[1].out;
         TMR2_OUT_O <= jmp_q[JMP_RT2] && cst[2].out;
         SER_RX_IRQ_O <= filt_q[IN_RX];
         SER_TX_IRQ_O <= filt_q[IN_TX];
         TMR1_IRQ_O <= jmp_q[JMP_IQ1] && cst[1].out;
         TMR2_IRQ_O <= jmp_q[JMP_IQ2] && cst[2].out;
         IRQ_O <= |(stat_q & mask_q);
      end
   end

   assign RDATA_O = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   AST_READ_LIVE: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && ADDR_I == ADR_CNT0 && !rd_hi_q[0] |=> RDATA_O == $past(cst[0].count[7:0]))
      else $error("live low byte wrong");
   AST_READ_PAIR: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && ADDR_I == ADR_CNT2 && !rd_hi_q[2] ##1 !RD_I && !WR_I
      ##1 RD_I && ADDR_I == ADR_CNT2 |=> RDATA_O == $past(cst[2].count[15:8], 3))
      else $error("high byte not from the low byte snapshot");
   AST_BAUD: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      $rose(cst[0].out) |=> BAUD_CLK_O)
      else $error("baud clock not following counter zero");
   AST_ROUTE1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      TMR1_OUT_O |-> $past(jmp_q[JMP_RT1]) && $past(cst[1].out))
      else $error("counter one output passed without jumper");
   AST_IRQ2: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      TMR2_IRQ_O |-> $past(jmp_q[JMP_IQ2]) && $past(cst[2].out))
      else $error("timer request passed without jumper");
   AST_RX_REQ: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      SER_RX_FULL_I [*5] |=> SER_RX_IRQ_O)
      else $error("receive request missing");
   AST_TX_REQ: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      !SER_TX_EMPTY_I [*5] |=> !SER_TX_IRQ_O)
      else $error("transmit request without empty buffer");
   AST_EVT_TICK: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      jmp_q[JMP_EVT_LO + 2] && !rise_q[IN_EVT + 2] && !rise_q[2] && !load_q[2]
      |=> $stable(cst[2].count))
      else $error("counter two moved without an event");
   AST_RDATA_IDLE: assert property (
      !RD_I |=> RDATA_O == BYTE_ZERO)
      else $error("read data outside answer cycle");
   AST_READ_LOW2: assert property (
      RD_I && ADDR_I == ADR_CNT2 && !rd_hi_q[2] |=> RDATA_O == $past(cst[2].count[7:0]))
      else $error("counter two low byte wrong");
   AST_READ_OUTS: assert property (
      RD_I && ADDR_I == ADR_LIVE |=> RDATA_O[2:0] == $past({cst[2].out, cst[1].out, cst[0].out}))
      else $error("live output bits wrong");
   AST_ROUTE2: assert property (
      TMR2_OUT_O |-> $past(jmp_q[JMP_RT2]) && $past(cst[2].out))
      else $error("counter two output passed without jumper");
   AST_IRQ1: assert property (
      TMR1_IRQ_O |-> $past(jmp_q[JMP_IQ1]) && $past(cst[1].out))
      else $error("timer one request without jumper");
   AST_IRQ_HIGH: assert property (
      |(stat_q & mask_q) |=> IRQ_O)
      else $error("request missing for unmasked status");
   AST_IRQ_LOW: assert property (
      !(|(stat_q & mask_q)) |=> !IRQ_O)
      else $error("request without unmasked status");
   AST_TC_STICKY: assert property (
      cst[1].tc |=> stat_q[1])
      else $error("terminal count not latched");
   AST_RX_STICKY: assert property (
      rise_q[IN_RX] |=> stat_q[ST_RX])
      else $error("receive event not latched");
   AST_TX_STICKY: assert property (
      rise_q[IN_TX] |=> stat_q[ST_TX])
      else $error("transmit event not latched");
   AST_RX_HOLD: assert property (
      stat_q[ST_RX] && !(RD_I && ADDR_I == ADR_STAT) |=> stat_q[ST_RX])
      else $error("receive status lost without read");
   AST_LOAD_HIGH: assert property (
      WR_I && ADDR_I == ADR_CNT2 && wr_hi_q[2] |=> load_q[2] && load_val_q[2][15:8] == $past(WDATA_I))
      else $error("high byte did not load");
   AST_CTRL_RESTART: assert property (
      WR_I && !RD_I && ADDR_I == ADR_CTRL && WDATA_I[CW_SEL_LO+:2] == 2'h2
      |=> cfg_wr_q[2] && !wr_hi_q[2] && !rd_hi_q[2])
      else $error("control write did not restart byte order");
   AST_RX_DROP: assert property (
      !SER_RX_FULL_I [*5] |=> !SER_RX_IRQ_O)
      else $error("receive request without character");
   AST_TX_SET: assert property (
      SER_TX_EMPTY_I [*5] |=> SER_TX_IRQ_O)
      else $error("transmit request missing");
   AST_TICK_GAP: assert property (
      int_tick_q |=> !int_tick_q)
      else $error("internal tick longer than one cycle");
   COV_EVT_TC: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
      jmp_q[JMP_EVT_LO + 2] && cst[2].tc);
   COV_IRQ: cover property (@(posedge REF_CLK_I) disable iff (RST_I) $rose(IRQ_O));
   COV_RATE_TC: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
      cst[1].tc ##[1:200] cst[1].tc);

endmodule // titq_top

/* File: include/titq_pkg.sv */
package titq_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clocking and timer input rates
   localparam int unsigned REF_PERIOD_NS = 100;
   localparam int unsigned FAST_IN_PERIOD_NS = 813;
   localparam int unsigned SLOW_IN_PERIOD_NS = 6500;
   // a rate: round down so the tick is never slower than printed
   localparam int unsigned FAST_DIV = FAST_IN_PERIOD_NS / REF_PERIOD_NS;
   localparam int unsigned SLOW_DIV = SLOW_IN_PERIOD_NS / REF_PERIOD_NS;
   localparam int unsigned DIV_W = 7;
   localparam logic [DIV_W-1:0] FAST_LIM = DIV_W'(FAST_DIV - 1);
   localparam logic [DIV_W-1:0] SLOW_LIM = DIV_W'(SLOW_DIV - 1);
   localparam logic [DIV_W-1:0] DIV_ZERO = 7'h00;

   ////////////////////////////////////////////////////////////////////////////
   // widths and register map
   localparam int unsigned NUM_CNT = 3;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned DAT_W = 8;
   localparam int unsigned ST_W = 5;
   localparam logic [3:0] ADR_CNT0 = 4'h0;
   localparam logic [3:0] ADR_CNT1 = 4'h1;
   localparam logic [3:0] ADR_CNT2 = 4'h2;
   localparam logic [3:0] ADR_CTRL = 4'h3;
   localparam logic [3:0] ADR_STAT = 4'h4;
   localparam logic [3:0] ADR_MASK = 4'h5;
   localparam logic [3:0] ADR_JMP = 4'h6;
   localparam logic [3:0] ADR_LIVE = 4'h7;
   // control word fields
   localparam int unsigned CW_SEL_LO = 6;
   localparam int unsigned CW_MODE_LO = 1;
   localparam int unsigned CW_BCD = 0;
   // jumper register fields
   localparam int unsigned JMP_RT1 = 0;
   localparam int unsigned JMP_RT2 = 1;
   localparam int unsigned JMP_IQ1 = 2;
   localparam int unsigned JMP_IQ2 = 3;
   localparam int unsigned JMP_EVT_LO = 4;
   localparam int unsigned JMP_SLOW = 7;
   // status fields
   localparam int unsigned ST_RX = 3;
   localparam int unsigned ST_TX = 4;
   localparam logic [DAT_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   typedef enum logic [5:0] {
      MD_TCINT = 6'b000001,
      MD_ONESHOT = 6'b000010,
      MD_RATE = 6'b000100,
      MD_SQUARE = 6'b001000,
      MD_SWSTB = 6'b010000,
      MD_HWSTB = 6'b100000
   } titq_mode_t;

   typedef struct packed {
      titq_mode_t mode;
      logic bcd;
   } titq_cfg_t;

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic out;
      logic tc;
   } titq_cst_t;

   // one step down, binary or four bcd digits; zero wraps to full scale
   function automatic logic [CNT_W-1:0] cnt_dec(input logic [CNT_W-1:0] v, input logic bcd);
      logic [CNT_W-1:0] r;
      logic borrow;
      r = v - CNT_ONE;
      borrow = 1'b1;
      if (bcd) begin
         r = v;
         for (int i = 0; i < 4; i++) begin
            if (borrow) begin
               if (v[i*4+:4] == 4'h0) begin
                  r[i*4+:4] = 4'h9;
               end else begin
                  r[i*4+:4] = v[i*4+:4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   // loaded value as a plain number of ticks; zero means full scale
   function automatic logic [16:0] to_bin(input logic [CNT_W-1:0] v, input logic bcd);
      logic [16:0] r;
      r = {1'b0, v};
      if (bcd) begin
         r = 17'(v[3:0]) + 17'(v[7:4]) * 17'h0_000A + 17'(v[11:8]) * 17'h0_0064
             + 17'(v[15:12]) * 17'h0_03E8;
         if (v == CNT_ZERO) r = 17'h0_2710;
      end else if (v == CNT_ZERO) begin
         r = 17'h1_0000;
      end
      return r;
   endfunction

endpackage

/* File: hdl/titq_counter.sv */
module titq_counter
   import titq_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // counting inputs
   input wire logic tick_i,
   input wire logic gate_i,
   input wire logic gate_rise_i,
   // programming
   input wire logic cfg_wr_i,
   input titq_cfg_t cfg_i,
   input wire logic load_i,
   input wire logic [CNT_W-1:0] load_val_i,
   // state
   output titq_cst_t st_o
);

   titq_cfg_t cfg_q;
   logic [CNT_W-1:0] reload_q, cnt_q, nxt;
   logic out_q, tc_q, run_q, at_one, trig_mode, gate_ok;
   logic [16:0] ph_q, ph_inc, nbin;

   assign nxt = cnt_dec(cnt_q, cfg_q.bcd);
   assign at_one = (cnt_q == CNT_ONE);
   assign nbin = to_bin(reload_q, cfg_q.bcd);
   assign ph_inc = ph_q + 17'h0_0001;
   assign trig_mode = (cfg_q.mode == MD_ONESHOT) || (cfg_q.mode == MD_HWSTB);
   // triggered functions run off the edge, not the gate level
   assign gate_ok = gate_i || trig_mode;
   assign st_o = '{count: cnt_q, out: out_q, tc: tc_q};

   always_ff @(posedge clk_i) begin
      if (rst_i) cfg_q <= '{mode: MD_TCINT, bcd: 1'b0};
      else if (cfg_wr_i) cfg_q <= cfg_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) reload_q <= CNT_ZERO;
      else if (load_i) reload_q <= load_val_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= CNT_ZERO;
         out_q <= 1'b1;
         run_q <= 1'b0;
         tc_q <= 1'b0;
         ph_q <= 17'h0_0000;
      end else begin
         tc_q <= 1'b0;
         if (cfg_wr_i) begin
            run_q <= 1'b0;
            out_q <= (cfg_i.mode != MD_TCINT);
         end else if (load_i) begin
            cnt_q <= load_val_i;
            ph_q <= 17'h0_0000;
            if (cfg_q.mode == MD_TCINT) begin
               out_q <= 1'b0;
               run_q <= 1'b1;
            end else if (!trig_mode) begin
               out_q <= 1'b1;
               run_q <= 1'b1;
            end
         end else if (gate_rise_i && trig_mode) begin
            cnt_q <= reload_q;
            run_q <= 1'b1;
            out_q <= (cfg_q.mode != MD_ONESHOT);
         end else if (!gate_i && (cfg_q.mode == MD_RATE || cfg_q.mode == MD_SQUARE)) begin
            out_q <= 1'b1;
         end else if (tick_i && run_q && gate_ok) begin
            unique case (cfg_q.mode)
               MD_TCINT: begin
                  cnt_q <= nxt;
                  if (at_one) begin
                     out_q <= 1'b1;
                     tc_q <= 1'b1;
                  end
               end
               MD_ONESHOT: begin
                  cnt_q <= nxt;
                  if (at_one) begin
                     out_q <= 1'b1;
                     tc_q <= 1'b1;
                     run_q <= 1'b0;
                  end
               end
               MD_RATE: begin
                  if (at_one) begin
                     cnt_q <= reload_q;
                     out_q <= 1'b1;
                  end else begin
                     cnt_q <= nxt;
                     if (nxt == CNT_ONE) begin
                        out_q <= 1'b0;
                        tc_q <= 1'b1;
                     end
                  end
               end
               MD_SQUARE: begin
                  if (at_one) begin
                     cnt_q <= reload_q;
                     ph_q <= 17'h0_0000;
                     out_q <= 1'b1;
                     tc_q <= 1'b1;
                  end else begin
                     cnt_q <= nxt;
                     ph_q <= ph_inc;
                     // odd counts give the extra tick to the high half
                     out_q <= ({ph_inc, 1'b0} < {1'b0, nbin});
                  end
               end
               MD_SWSTB, MD_HWSTB: begin
                  if (!out_q) begin
                     out_q <= 1'b1;
                     run_q <= 1'b0;
                  end else begin
                     cnt_q <= nxt;
                     if (at_one) begin
                        out_q <= 1'b0;
                        tc_q <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_TC_AT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      tc_q && cfg_q.mode inside {MD_TCINT, MD_ONESHOT, MD_SWSTB, MD_HWSTB} |-> cnt_q == CNT_ZERO)
      else $error("terminal count flagged away from zero");
   AST_TCINT_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_q.mode == MD_TCINT && load_i && !cfg_wr_i |=> !out_q && run_q)
      else $error("interrupt function did not start low");
   AST_ONESHOT_TRIG: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_q.mode == MD_ONESHOT && gate_rise_i && !cfg_wr_i && !load_i
      |=> !out_q && cnt_q == $past(reload_q))
      else $error("one-shot trigger did not restart low");
   AST_RATE_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_q.mode == MD_RATE && !out_q && tick_i && gate_i && !cfg_wr_i && !load_i
      |=> out_q && cnt_q == $past(reload_q))
      else $error("rate pulse longer than one tick");
   AST_SQ_LOW_HALF: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_q.mode == MD_SQUARE && run_q && !out_q |-> {ph_q, 1'b0} >= {1'b0, nbin})
      else $error("square wave low in first half");
   AST_SW_LOAD_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_q.mode == MD_SWSTB && load_i && !cfg_wr_i |=> out_q && cnt_q == $past(load_val_i))
      else $error("software strobe not high after load");
   AST_STROBE_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      (cfg_q.mode == MD_SWSTB || cfg_q.mode == MD_HWSTB) && !out_q && tick_i && gate_ok
      && !cfg_wr_i && !load_i && !gate_rise_i |=> out_q && !run_q)
      else $error("strobe longer than one tick");
   COV_SQ_FALL: cover property (@(posedge clk_i) disable iff (rst_i)
      cfg_q.mode == MD_SQUARE && $fell(out_q));
   COV_ONESHOT_TC: cover property (@(posedge clk_i) disable iff (rst_i)
      cfg_q.mode == MD_ONESHOT && tc_q);

endmodule // titq_counter

/* File: tb/titq_host.sv */
module titq_host
   import titq_pkg::*;
(
   // bus
   input wire logic clk_i,
   output logic [3:0] addr_o,
   output logic [DAT_W-1:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [DAT_W-1:0] rdata_i
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      addr_o = 4'h0;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // strobe dropped a full cycle before the next request, so no double drive
   task automatic wr(input logic [3:0] a, input logic [DAT_W-1:0] d);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, output logic [DAT_W-1:0] d);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1;
      d = rdata_i;
      @(posedge clk_i);
   endtask
endmodule // titq_host

/* File: tb/titq_top_tb.sv */
module titq_top_tb;
   import titq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, wr, rd, rxf, txe, baud, o1, o2, rxq, txq, q1, q2, irq;
   logic [3:0] adr;
   logic [7:0] wd, rdat, d, e, f;
   logic [2:0] gt, ev;
   int err_total = 0;
   int comparisons = 0;
   titq_host u_host (.clk_i(clk), .addr_o(adr), .wdata_o(wd), .wr_o(wr), .rd_o(rd),
      .rdata_i(rdat));
   titq_top u_dut (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(adr), .WDATA_I(wd), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdat), .GATE_I(gt), .EVT_CLK_I(ev), .SER_RX_FULL_I(rxf),
      .SER_TX_EMPTY_I(txe), .BAUD_CLK_O(baud), .TMR1_OUT_O(o1), .TMR2_OUT_O(o2),
      .SER_RX_IRQ_O(rxq), .SER_TX_IRQ_O(txq), .TMR1_IRQ_O(q1), .TMR2_IRQ_O(q2), .IRQ_O(irq));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      comparisons++;
      if (g !== x) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, x, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // rate generator on the baud counter, then live reads
   task automatic t_rate();
      int t0, t1, lw;
      logic p;
      t0 = 0;
      t1 = 0;
      lw = 0;
      p = 1'b1;
      u_host.wr(ADR_CTRL, 8'h04);
      u_host.wr(ADR_CNT0, 8'h04);
      u_host.wr(ADR_CNT0, 8'h00);
      for (int i = 1; i < 300; i++) begin
         @(posedge clk);
         #1;
         if (t0 != 0 && t1 == 0 && baud === 1'b0) lw++;
         if (baud === 1'b0 && p === 1'b1) begin
            if (t0 == 0) t0 = i;
            else if (t1 == 0) t1 = i;
         end
         p = baud;
      end
      @(posedge clk);
      chk("period", 16'(4 * FAST_DIV), 16'(t1 - t0));
      chk("low", 16'(FAST_DIV), 16'(lw));
      u_host.rd(ADR_CNT0, d);
      u_host.rd(ADR_CNT0, e);
      chk("hi", 16'h0000, {8'h00, e});
      repeat (FAST_DIV) @(posedge clk);
      u_host.rd(ADR_CNT0, e);
      u_host.rd(ADR_CNT0, f);
      chk("live", 16'h0001, 16'(d !== e));
      $display("rate test end");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // terminal count interrupt on counter one, jumpers and mask
   task automatic t_tc();
      u_host.wr(ADR_JMP, 8'h04);
      u_host.wr(ADR_MASK, 8'h02);
      u_host.wr(ADR_CTRL, 8'h40);
      u_host.wr(ADR_CNT1, 8'h03);
      u_host.wr(ADR_CNT1, 8'h00);
      repeat (4) @(posedge clk);
      chk("q1 load", 16'h0000, 16'(q1));
      repeat (3 * FAST_DIV + 12) @(posedge clk);
      chk("q1 tc", 16'h0001, 16'(q1));
      chk("o1 off", 16'h0000, 16'(o1));
      chk("q2 off", 16'h0000, 16'(q2));
      chk("irq", 16'h0001, 16'(irq));
      u_host.rd(ADR_STAT, d);
      chk("st tc1", 16'h0002, 16'(d & 8'h02));
      u_host.wr(ADR_JMP, 8'h05);
      repeat (2) @(posedge clk);
      chk("irq clr", 16'h0000, 16'(irq));
      chk("o1 on", 16'h0001, 16'(o1));
      chk("o2", 16'h0000, 16'(o2));
      $display("tc test end");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // serial buffer requests
   task automatic t_ser();
      u_host.wr(ADR_MASK, 8'h18);
      rxf <= 1'b1;
      repeat (8) @(posedge clk);
      chk("rxq", 16'h0001, 16'(rxq));
      chk("irq rx", 16'h0001, 16'(irq));
      u_host.rd(ADR_STAT, d);
      chk("st rx", 16'h0008, 16'(d & 8'h18));
      txe <= 1'b1;
      repeat (8) @(posedge clk);
      chk("txq", 16'h0001, 16'(txq));
      u_host.rd(ADR_STAT, d);
      chk("st tx", 16'h0010, 16'(d & 8'h18));
      u_host.rd(ADR_STAT, d);
      chk("st clr", 16'h0000, 16'(d & 8'h18));
      $display("serial test end");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // one-shot bcd event counter on counter two
   task automatic t_evt();
      u_host.wr(ADR_JMP, 8'h42);
      u_host.wr(ADR_CTRL, 8'h83);
      u_host.wr(ADR_CNT2, 8'h10);
      u_host.wr(ADR_CNT2, 8'h00);
      chk("o2 idle", 16'h0001, 16'(o2));
      gt[2] <= 1'b0;
      repeat (6) @(posedge clk);
      gt[2] <= 1'b1;
      repeat (8) @(posedge clk);
      chk("o2 trig", 16'h0000, 16'(o2));
      for (int i = 0; i < 10; i++) begin
         ev[2] <= 1'b1;
         repeat (6) @(posedge clk);
         ev[2] <= 1'b0;
         repeat (6) @(posedge clk);
         if (i == 0) begin
            u_host.rd(ADR_CNT2, d);
            u_host.rd(ADR_CNT2, e);
            chk("bcd", 16'h0009, {e, d});
         end
         if (i == 8) chk("o2 run", 16'h0000, 16'(o2));
      end
      chk("o2 tc", 16'h0001, 16'(o2));
      $display("event test end");
   endtask
   initial begin
      rst = 1'b1;
      rxf = 1'b0;
      txe = 1'b0;
      gt = 3'b111;
      ev = 3'b000;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("baud rst", 16'h0001, 16'(baud));
      chk("irq rst", 16'h0000, 16'(irq));
      t_rate();
      t_tc();
      t_ser();
      t_evt();
      stop_test();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule // titq_top_tb
